/* design/pwr_seq_pkg.sv */
// shared constants and carrier types for the power-up reset sequencer
package pwr_seq_pkg;
  // oscillator period and documented delays, all in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_CORE_SETTLE_NS = 5000;
  localparam int unsigned T_KEY_FILTER_NS = 12700000;
  localparam int unsigned T_POR_DELAY_NS = 128000;
  localparam int unsigned T_VCC_UV_FILTER_NS = 10000;
  // cycle counts derived from the delays
  localparam int unsigned CORE_SETTLE_CYCLES = T_CORE_SETTLE_NS / CLK_PERIOD_NS;
  localparam int unsigned KEY_FILTER_CYCLES = T_KEY_FILTER_NS / CLK_PERIOD_NS;
  localparam int unsigned POR_DELAY_CYCLES = T_POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned VCC_UV_FILTER_CYCLES = T_VCC_UV_FILTER_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;

  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_CORE_WAIT = 3'h1,
    ST_KEY_FILTER = 3'h2,
    ST_PREREG_UP = 3'h3,
    ST_SUPPLY_UP = 3'h4,
    ST_POR_TIMING = 3'h5,
    ST_RUN = 3'h6,
    ST_OV_OFF = 3'h7
  } seq_state_type;

  // comparator and key levels from the analog section
  typedef struct packed {
    logic key;
    logic prereg_ok;
    logic vcc_por_ok;
    logic vcc_uv;
    logic battery_ov;
  } sense_type;

  localparam int unsigned SENSE_W = $bits(sense_type);
  localparam logic [SENSE_W-1:0] SENSE_RST = 5'h0;

  // enables towards bias, core, regulators and drivers
  typedef struct packed {
    logic bias;
    logic core_osc;
    logic prereg;
    logic vcc;
    logic sensor;
    logic drivers;
  } supply_en_type;

  localparam supply_en_type SUPPLY_EN_RST = 6'h0;
endpackage

/* design/power_up_reset_sequencer.sv */
// power-up sequencer, supply enables and mcu reset generator
`timescale 1ns/1ns
module power_up_reset_sequencer #(
  parameter int unsigned KEY_FILTER_CYCLES = pwr_seq_pkg::KEY_FILTER_CYCLES,
  parameter int unsigned POR_DELAY_CYCLES = pwr_seq_pkg::POR_DELAY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire pwr_seq_pkg::sense_type sense_i,
  input wire logic sensor_supply_sw_en_i,
  input wire logic watchdog_timeout_i,
  input wire logic mcu_reset_n_in_i,
  output pwr_seq_pkg::supply_en_type supply_en_o,
  output logic core_power_good_n_o,
  output logic mcu_reset_n_out_o,
  output logic mcu_reset_oe_o
);

  // counts that the counter compare cannot serve
  if (KEY_FILTER_CYCLES < 1 || POR_DELAY_CYCLES < 1) begin : g_bad_param
    $error("delay parameters must be at least one cycle");
  end

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  logic [pwr_seq_pkg::SENSE_W-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
  pwr_seq_pkg::sense_type sense;
  pwr_seq_pkg::seq_state_type state_reg, state_next;
  logic [pwr_seq_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [pwr_seq_pkg::CNT_W-1:0] uv_cnt_reg;
  logic uv_event;
  pwr_seq_pkg::supply_en_type en_next;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // three-flop pin sampling; a level counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= pwr_seq_pkg::SENSE_RST;
      s2_reg <= pwr_seq_pkg::SENSE_RST;
      s3_reg <= pwr_seq_pkg::SENSE_RST;
      flt_reg <= pwr_seq_pkg::SENSE_RST;
    end else begin
      s1_reg <= sense_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
    end
  end
  assign sense = flt_reg;

  // undervoltage must persist past the filter time before it counts
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      uv_cnt_reg <= pwr_seq_pkg::CNT_ZERO;
    end else if (sense.vcc_uv && state_reg == pwr_seq_pkg::ST_RUN) begin
      if (uv_cnt_reg <= pwr_seq_pkg::VCC_UV_FILTER_CYCLES) begin
        uv_cnt_reg <= uv_cnt_reg + pwr_seq_pkg::CNT_ONE;
      end
    end else begin
      uv_cnt_reg <= pwr_seq_pkg::CNT_ZERO;
    end
  end
  assign uv_event = uv_cnt_reg > pwr_seq_pkg::VCC_UV_FILTER_CYCLES;

  // sequencer; key loss takes priority over every step, overvoltage over every step from pre-regulator start on
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + pwr_seq_pkg::CNT_ONE;
    if (!sense.key) begin
      state_next = pwr_seq_pkg::ST_OFF;
      cnt_next = pwr_seq_pkg::CNT_ZERO;
    end else if (sense.battery_ov && state_reg inside {pwr_seq_pkg::ST_PREREG_UP,
                 pwr_seq_pkg::ST_SUPPLY_UP, pwr_seq_pkg::ST_POR_TIMING,
                 pwr_seq_pkg::ST_RUN, pwr_seq_pkg::ST_OV_OFF}) begin
      // early steps keep their timers; leaving them would skip the key filter
      state_next = pwr_seq_pkg::ST_OV_OFF;
      cnt_next = pwr_seq_pkg::CNT_ZERO;
    end else begin
      case (state_reg)
        pwr_seq_pkg::ST_OFF: begin
          state_next = pwr_seq_pkg::ST_CORE_WAIT;
          cnt_next = pwr_seq_pkg::CNT_ZERO;
        end
        pwr_seq_pkg::ST_CORE_WAIT: begin
          if (cnt_reg >= pwr_seq_pkg::CORE_SETTLE_CYCLES - 1) begin
            state_next = pwr_seq_pkg::ST_KEY_FILTER;
            cnt_next = pwr_seq_pkg::CNT_ZERO;
          end
        end
        pwr_seq_pkg::ST_KEY_FILTER: begin
          if (cnt_reg >= KEY_FILTER_CYCLES - 1) begin
            if (sense.battery_ov) begin
              cnt_next = cnt_reg;
            end else begin
              state_next = pwr_seq_pkg::ST_PREREG_UP;
              cnt_next = pwr_seq_pkg::CNT_ZERO;
            end
          end
        end
        pwr_seq_pkg::ST_PREREG_UP: begin
          if (sense.prereg_ok) begin
            state_next = pwr_seq_pkg::ST_SUPPLY_UP;
          end
          cnt_next = pwr_seq_pkg::CNT_ZERO;
        end
        pwr_seq_pkg::ST_SUPPLY_UP: begin
          if (sense.vcc_por_ok) begin
            state_next = pwr_seq_pkg::ST_POR_TIMING;
          end
          cnt_next = pwr_seq_pkg::CNT_ZERO;
        end
        pwr_seq_pkg::ST_POR_TIMING: begin
          // vcc dropping below por restarts the full delay
          if (!sense.vcc_por_ok) begin
            cnt_next = pwr_seq_pkg::CNT_ZERO;
          end else if (cnt_reg >= POR_DELAY_CYCLES - 1) begin
            state_next = pwr_seq_pkg::ST_RUN;
            cnt_next = pwr_seq_pkg::CNT_ZERO;
          end
        end
        pwr_seq_pkg::ST_RUN: begin
          cnt_next = pwr_seq_pkg::CNT_ZERO;
          if (uv_event || watchdog_timeout_i) begin
            state_next = pwr_seq_pkg::ST_POR_TIMING;
          end
        end
        pwr_seq_pkg::ST_OV_OFF: begin
          // supplies restart from the pre-regulator once overvoltage clears
          cnt_next = pwr_seq_pkg::CNT_ZERO;
          state_next = pwr_seq_pkg::ST_PREREG_UP;
        end
        default: begin
          state_next = pwr_seq_pkg::ST_OFF;
          cnt_next = pwr_seq_pkg::CNT_ZERO;
        end
      endcase
    end
  end

  // state and delay counter
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pwr_seq_pkg::ST_OFF;
      cnt_reg <= pwr_seq_pkg::CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // enable decode from the next state so outputs leave flops aligned
  always_comb begin
    en_next.bias = state_next != pwr_seq_pkg::ST_OFF;
    en_next.core_osc = en_next.bias && state_next != pwr_seq_pkg::ST_CORE_WAIT;
    en_next.prereg = state_next inside {pwr_seq_pkg::ST_PREREG_UP, pwr_seq_pkg::ST_SUPPLY_UP,
                                        pwr_seq_pkg::ST_POR_TIMING, pwr_seq_pkg::ST_RUN};
    en_next.vcc = state_next inside {pwr_seq_pkg::ST_SUPPLY_UP, pwr_seq_pkg::ST_POR_TIMING,
                                     pwr_seq_pkg::ST_RUN};
    en_next.sensor = en_next.vcc && sensor_supply_sw_en_i;
    en_next.drivers = state_next == pwr_seq_pkg::ST_RUN;
  end

  // registered outputs; the reset pin only ever pulls low
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      supply_en_o <= pwr_seq_pkg::SUPPLY_EN_RST;
      core_power_good_n_o <= 1'b0;
      mcu_reset_n_out_o <= 1'b0;
      mcu_reset_oe_o <= 1'b1;
    end else begin
      supply_en_o <= en_next;
      core_power_good_n_o <= en_next.core_osc;
      mcu_reset_n_out_o <= 1'b0;
      mcu_reset_oe_o <= state_next != pwr_seq_pkg::ST_RUN;
    end
  end

  // checks on the sequence
  a_ov_all_off: assert property (@(posedge clk_i) disable iff (!rst_n)
    sense.battery_ov && sense.key |=> !supply_en_o.prereg && !supply_en_o.vcc && !supply_en_o.drivers)
    else $error("supplies on during overvoltage");
  a_por_release: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(mcu_reset_oe_o) |-> $past(state_reg) == pwr_seq_pkg::ST_POR_TIMING
    && $past(cnt_reg) == POR_DELAY_CYCLES - 1 && $past(sense.vcc_por_ok))
    else $error("reset released outside por timing");
  a_por_held_low: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_reg == pwr_seq_pkg::ST_POR_TIMING && cnt_reg < POR_DELAY_CYCLES - 1 |=> mcu_reset_oe_o)
    else $error("reset released before por delay");
  a_uv_reset: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_reg == pwr_seq_pkg::ST_RUN && uv_event && sense.key && !sense.battery_ov
    |=> mcu_reset_oe_o && state_reg == pwr_seq_pkg::ST_POR_TIMING)
    else $error("undervoltage did not assert reset");
  a_sensor_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
    supply_en_o.sensor |-> supply_en_o.vcc && $past(sensor_supply_sw_en_i))
    else $error("sensor supply on while disabled");
  a_key_bias: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_reg == pwr_seq_pkg::ST_OFF && sense.key |=> supply_en_o.bias ##0 !core_power_good_n_o)
    else $error("key did not enable bias");
  a_core_delay: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(core_power_good_n_o) |-> $past(cnt_reg) == pwr_seq_pkg::CORE_SETTLE_CYCLES - 1)
    else $error("core released at wrong time");
  a_key_filter: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(supply_en_o.prereg) && $past(state_reg) == pwr_seq_pkg::ST_KEY_FILTER
    |-> $past(cnt_reg) == KEY_FILTER_CYCLES - 1)
    else $error("pre-regulator enabled early");
  a_vcc_after_pp: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(supply_en_o.vcc) |-> $past(sense.prereg_ok) && supply_en_o.prereg)
    else $error("vcc enabled without pre-regulator good");
  a_wdog_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_reg == pwr_seq_pkg::ST_RUN && watchdog_timeout_i && sense.key |=> mcu_reset_oe_o [*2])
    else $error("watchdog timeout gave no reset");

  c_reach_run: cover property (@(posedge clk_i) disable iff (!rst_n)
    $fell(mcu_reset_oe_o));
  c_uv_event: cover property (@(posedge clk_i) disable iff (!rst_n)
    state_reg == pwr_seq_pkg::ST_RUN && uv_event);
  c_ov_off: cover property (@(posedge clk_i) disable iff (!rst_n)
    state_reg == pwr_seq_pkg::ST_OV_OFF);
  c_pin_released: cover property (@(posedge clk_i) disable iff (!rst_n)
    !mcu_reset_oe_o && mcu_reset_n_in_i);

endmodule // power_up_reset_sequencer

/* dv/mcu_supply_model.sv */
// far-side model: regulated rails behind the enables and the mcu reset pin
`timescale 1ns/1ns
module mcu_supply_model #(
  parameter int unsigned RAMP_CYCLES = 40
) (
  input wire logic clk_i,
  input wire pwr_seq_pkg::supply_en_type supply_en_i,
  input wire logic reset_oe_i,
  input wire logic reset_drive_i,
  input wire logic brownout_i,
  output logic prereg_ok_o,
  output logic vcc_por_ok_o,
  output logic vcc_uv_o,
  output logic reset_pin_o
);
  int unsigned pp_cnt = 0;
  int unsigned vcc_cnt = 0;
  // rails ramp slowly under soft start but collapse at once when disabled
  always @(posedge clk_i) begin
    pp_cnt <= !supply_en_i.prereg ? 0 : (pp_cnt < RAMP_CYCLES) ? pp_cnt + 1 : pp_cnt;
    vcc_cnt <= !supply_en_i.vcc ? 0 : (vcc_cnt < RAMP_CYCLES) ? vcc_cnt + 1 : vcc_cnt;
  end
  // comparator levels; a brownout pulls vcc below both thresholds
  assign prereg_ok_o = (pp_cnt == RAMP_CYCLES);
  assign vcc_por_ok_o = (vcc_cnt == RAMP_CYCLES) && !brownout_i;
  assign vcc_uv_o = !vcc_por_ok_o;
  // open drain: pull-up to vcc, internal pull-down when unpowered
  assign reset_pin_o = reset_oe_i ? reset_drive_i : supply_en_i.vcc;
endmodule // mcu_supply_model

/* dv/power_up_reset_sequencer_tb.sv */
// self-checking bench for the power-up reset sequencer
`timescale 1ns/1ns
module power_up_reset_sequencer_tb;
  localparam int unsigned KF = 20;
  localparam int unsigned POR = 16;
  typedef struct {logic [7:0] v; int gap;} note_type;
  note_type notes[$];
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic key = 1'b0, ov = 1'b0, sw_en = 1'b1, wd = 1'b0, brown = 1'b0, sen;
  logic pp_ok, por_ok, uv, pin, rst_n_out, rst_oe, cpg_n;
  logic [7:0] last = 8'h01, got, rnd = 8'h31;
  pwr_seq_pkg::sense_type sense;
  pwr_seq_pkg::supply_en_type en;
  int err_total = 0, compares = 0, cyc = 0, last_cyc = 0;
  note_type n;

  always #5 clk_i = ~clk_i;
  assign sense = {key, pp_ok, por_ok, uv, ov};
  assign got = {en, cpg_n, rst_oe};

  power_up_reset_sequencer #(.KEY_FILTER_CYCLES(KF), .POR_DELAY_CYCLES(POR)) DUT (
    .clk_i(clk_i), .rstn_i(rstn_i), .sense_i(sense), .sensor_supply_sw_en_i(sw_en),
    .watchdog_timeout_i(wd), .mcu_reset_n_in_i(pin), .supply_en_o(en),
    .core_power_good_n_o(cpg_n), .mcu_reset_n_out_o(rst_n_out), .mcu_reset_oe_o(rst_oe));
  mcu_supply_model #(.RAMP_CYCLES(40)) partner (
    .clk_i(clk_i), .supply_en_i(en), .reset_oe_i(rst_oe), .reset_drive_i(rst_n_out),
    .brownout_i(brown), .prereg_ok_o(pp_ok), .vcc_por_ok_o(por_ok), .vcc_uv_o(uv),
    .reset_pin_o(pin));

  // 8-bit lfsr, taps 8 6 5 4
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk_val(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // gaps between two output changes are exact: both already sit behind the filter
  task automatic chk_gap(input int e, input int g);
    compares++;
    if (g != e) begin
      err_total++;
      $display("wrong value at %0t: gap expected %h got %h", $time, e, g);
    end
  endtask
  task automatic note(input logic [5:0] e, input logic c, input logic o, input int gap);
    notes.push_back('{{e, c, o}, gap});
  endtask
  // bounded wait until every noted change has been seen
  task automatic settle(input string name, input int lim);
    int i;
    i = 0;
    while (notes.size() != 0 && i < lim) begin
      @(negedge clk_i);
      i++;
    end
    chk_val(8'h00, 8'(notes.size()));
    notes.delete();
    $display("test %s done", name);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watcher: every change of the enables or reset pin must match the oldest note
  always @(negedge clk_i) begin
    cyc++;
    if (rstn_i && got !== last) begin
      if (notes.size() == 0) begin
        chk_val(last, got);
      end else begin
        n = notes.pop_front();
        chk_val(n.v, got);
        chk_val({7'h00, n.v[4] & ~n.v[0]}, {7'h00, pin});
        if (n.gap != 0) chk_gap(n.gap, cyc - last_cyc);
      end
      last = got;
      last_cyc = cyc;
    end
  end

  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  initial begin
    rnd = lfsr(rnd);
    sen = rnd[0];
    sw_en = sen;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    note(6'b100000, 1'b0, 1'b1, 0);
    note(6'b110000, 1'b1, 1'b1, pwr_seq_pkg::CORE_SETTLE_CYCLES);
    note(6'b111000, 1'b1, 1'b1, KF);
    note({4'b1111, sen, 1'b0}, 1'b1, 1'b1, 0);
    note({4'b1111, sen, 1'b1}, 1'b1, 1'b0, 0);
    key = 1'b1;
    settle("power_up", 2000);
    // watchdog pulse: reset lasts exactly the por delay
    note({4'b1111, sen, 1'b0}, 1'b1, 1'b1, 0);
    note({4'b1111, sen, 1'b1}, 1'b1, 1'b0, POR);
    wd = 1'b1;
    @(negedge clk_i);
    wd = 1'b0;
    settle("watchdog", 200);
    // glitch shorter than the uv filter must not reset
    rnd = lfsr(rnd);
    brown = 1'b1;
    repeat (100 + 2 * int'(rnd)) @(negedge clk_i);
    brown = 1'b0;
    // let the filtered level fall so the next dip starts a fresh count
    repeat (20) @(negedge clk_i);
    settle("uv_glitch", 60);
    note({4'b1111, sen, 1'b0}, 1'b1, 1'b1, 0);
    note({4'b1111, sen, 1'b1}, 1'b1, 1'b0, 0);
    brown = 1'b1;
    repeat (1100) @(negedge clk_i);
    brown = 1'b0;
    settle("uv_reset", 300);
    sen = ~sen;
    note({4'b1111, sen, 1'b1}, 1'b1, 1'b0, 0);
    sw_en = sen;
    settle("sensor_sw", 20);
    note(6'b110000, 1'b1, 1'b1, 0);
    ov = 1'b1;
    settle("ov_on", 50);
    note(6'b111000, 1'b1, 1'b1, 0);
    note({4'b1111, sen, 1'b0}, 1'b1, 1'b1, 0);
    note({4'b1111, sen, 1'b1}, 1'b1, 1'b0, 0);
    ov = 1'b0;
    settle("ov_off", 300);
    note(6'b000000, 1'b0, 1'b1, 0);
    key = 1'b0;
    settle("key_off", 50);
    end_sim();
  end
endmodule // power_up_reset_sequencer_tb
